//--- include/csit_pkg.sv
/*
 * Shared constants for the clock select and interval timer block:
 * register indexes, field positions, reset values and divide ratios.
 * Assumes an 8-bit register file behind a 32-bit Wishbone slave.
 */
package csit_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [9:0] CPU_RSVD_IDX   = 10'h030;
    localparam logic [9:0] TMR_CFG_IDX    = 10'h031;
    localparam logic [9:0] OSC_CTL0_IDX   = 10'h1e0;
    localparam logic [9:0] RELOAD_LO_IDX  = 10'h040;
    localparam logic [9:0] RELOAD_HI_IDX  = 10'h041;
    localparam logic [9:0] COUNT_LO_IDX   = 10'h042;
    localparam logic [9:0] COUNT_HI_IDX   = 10'h043;
    localparam logic [9:0] STATUS_IDX     = 10'h044;

    // Reset values
    localparam logic [7:0]  TMR_CFG_RST   = 8'h8f;
    localparam logic [7:0]  OSC_CTL0_RST  = 8'h08;
    localparam logic [11:0] RELOAD_RST    = 12'h000;

    // Oscillator control zero fields
    localparam int CONT_MON_BIT  = 5;
    localparam int SLEEP_SEL_LSB = 3;
    localparam int CPU_SPD_LSB   = 0;

    // Timer clock config fields
    localparam int CAP_DIV_LSB = 6;
    localparam int CAP_SEL_LSB = 4;
    localparam int INT_DIV_LSB = 2;
    localparam int INT_SEL_LSB = 0;

    // Status register fields
    localparam int ST_INT_SEL_LSB = 0;
    localparam int ST_CAP_SEL_LSB = 2;
    localparam int ST_INT_PEND    = 4;
    localparam int ST_CAP_PEND    = 5;

    // Timer clock source codes
    localparam logic [1:0] SRC_FAST = 2'h0;
    localparam logic [1:0] SRC_SLOW = 2'h2;
    localparam logic [1:0] SRC_CAP  = 2'h3;   // Interval source only
    localparam logic [1:0] SRC_STOP = 2'h3;   // Capture source only

    // Divide ratios in oscillator and capture ticks
    localparam int DIV_W            = 16;
    localparam logic [15:0] SLEEP_BASE_DIV = 16'h0040;   // 32 kHz / 64 = 512 Hz
    localparam int SLEEP_STEP_SHIFT = 3;                 // Each code step is /8
    localparam int FIXED_INTERVAL_US  = 1024;
    localparam int CAPTURE_NOMINAL_MHZ = 4;
    localparam logic [15:0] FIXED_DIV = 16'(FIXED_INTERVAL_US * CAPTURE_NOMINAL_MHZ);

    localparam int PIT_W = 12;

    // Processor clock divide from the 24 MHz oscillator
    function automatic logic [15:0] cpu_divisor(input logic [2:0] spd);
        unique case (spd)
            3'h0:    cpu_divisor = 16'h0008;   // 3 MHz
            3'h1:    cpu_divisor = 16'h0004;   // 6 MHz
            3'h2:    cpu_divisor = 16'h0002;   // 12 MHz
            3'h4:    cpu_divisor = 16'h0010;   // 1.5 MHz
            3'h5:    cpu_divisor = 16'h0020;   // 750 kHz
            3'h6:    cpu_divisor = 16'h0080;   // 187 kHz
            default: cpu_divisor = 16'h0008;   // Reserved codes run at 3 MHz
        endcase
    endfunction : cpu_divisor

endpackage : csit_pkg

//--- include/csit_pit_if.sv
/*
 * Carrier between the register file and the interval down-counter.
 * Assumes both ends share clk and arst_n.
 */
`timescale 1ns/100ps
`default_nettype none

interface csit_pit_if;
    logic [11:0] reload_value;
    logic [11:0] count;
    logic        reload_pulse;

    modport timer (input reload_value, output count, output reload_pulse);
    modport ctrl  (output reload_value, input count, input reload_pulse);
endinterface : csit_pit_if

`default_nettype wire

//--- verilog/csit_div.sv
/*
 * Programmable tick divider: one output pulse per divisor input ticks.
 * Assumes tick_in is a one-cycle enable in the clk domain.
 */
`timescale 1ns/100ps
`default_nettype none

module csit_div
    import csit_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] divisor,
    output var  logic         tick_out
);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] last;

    // Divisor 0 behaves as 1; a shrunk divisor wraps at once
    assign last = (divisor == '0) ? '0 : divisor - W'(1);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg  <= '0;
            tick_out <= 1'b0;
        end else if (tick_in) begin
            if (cnt_reg >= last) begin
                cnt_reg  <= '0;
                tick_out <= 1'b1;
            end else begin
                cnt_reg  <= cnt_reg + W'(1);
                tick_out <= 1'b0;
            end
        end else begin
            tick_out <= 1'b0;
        end
    end

endmodule : csit_div

`default_nettype wire

//--- verilog/csit_pit.sv
/*
 * Reloading 12-bit down-counter of the interval timer.
 * Assumes tick is the interval timer clock enable, one cycle wide.
 */
`timescale 1ns/100ps
`default_nettype none

module csit_pit
    import csit_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic tick,
    csit_pit_if.timer pit
);

    logic [PIT_W-1:0] count_reg;
    logic             reload_reg;

    // Count down; the tick after zero loads the reload value
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg  <= '0;
            reload_reg <= 1'b0;
        end else if (tick) begin
            if (count_reg == '0) begin
                count_reg  <= pit.reload_value;   // see RULE_12
                reload_reg <= 1'b1;               // see RULE_13
            end else begin
                count_reg  <= count_reg - PIT_W'(1);
                reload_reg <= 1'b0;
            end
        end else begin
            reload_reg <= 1'b0;
        end
    end

    assign pit.count        = count_reg;
    assign pit.reload_pulse = reload_reg;

endmodule : csit_pit

`default_nettype wire

//--- verilog/csit_top.sv
/*
 * Clock select and interval timer: processor clock rate, sleep tick,
 * capture and interval timer clocks, supply monitor gating, 12-bit
 * interval timer and its interrupt, behind a classic Wishbone slave.
 * Assumes oscillator edges arrive as one-cycle tick inputs synchronous
 * to clk, and that clk is faster than the fastest oscillator tick.
 */
// Overview of operation
// RULE_01: CPU speed code picks 3, 6, 12, 1.5 MHz, 750 or 187 kHz.
// RULE_02: CPU speed field resets to zero, giving 3 MHz.
// RULE_03: Sleep field picks 512, 64, 8 or 1 Hz sleep tick.
// RULE_04: Continuous-monitor set keeps supply detection on throughout sleep.
// RULE_05: Continuous-monitor clear powers supply detection per sleep duty cycle.
// RULE_06: Supply detection duty cycling is independent of sleep interval.
// RULE_07: Capture divider codes divide by 2, 4, 6 or 8.
// RULE_08: Capture source: fast oscillator, slow oscillator, or stopped.
// RULE_09: Interval divider codes divide by 1, 2, 3 or 4.
// RULE_10: Interval source: fast oscillator, slow oscillator or capture clock.
// RULE_11: Source switch completes only while old and new clocks run; stopping the capture clock here needs only the old one.
// RULE_12: Interval timer is 12-bit down counter reloading after zero.
// RULE_13: Interval timer requests an interrupt on every reload; reloads that come while a request is still pending merge into one.
// RULE_14: Reload value is read/write while running; firmware avoids split reloads.
// RULE_15: Firmware rereads the counter until two readings agree on slow clock.
// RULE_16: Fixed 1024 us timer derives from capture clock, scaling with it.
// RULE_17: Firmware loads oscillator gain for supply, 0xFF at 2.70 V.
// RULE_18: Gain is 0x40 at 3.3 or 3.0 V, 0xFF at 2.85 V.
// RULE_19: Firmware takes oscillator trims from the supervisory table entries.
// RULE_20: Interrupt is one pulse, aligned to the processor clock enable.
`timescale 1ns/100ps
`default_nettype none

module csit_top
    import csit_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [11:0] wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output var  logic [31:0] wb_dat_r,
    output var  logic        wb_ack,
    input  wire logic        fast_osc_tick,
    input  wire logic        slow_osc_tick,
    input  wire logic        fast_osc_running,
    input  wire logic        slow_osc_running,
    input  wire logic        sleep_active,
    input  wire logic        sleep_duty_on,
    output var  logic        processor_clock_en,
    output var  logic        capture_clock_en,
    output var  logic        interval_clock_en,
    output var  logic        sleep_tick,
    output var  logic        fixed_interval_tick,
    output var  logic        interval_irq,
    output var  logic        supply_monitor_en
);

    // Register file state
    logic [7:0]       osc_ctl0_reg;
    logic [7:0]       tmr_cfg_reg;
    logic [PIT_W-1:0] reload_reg;
    logic [1:0]       cap_sel_reg;      // Source actually in use
    logic [1:0]       int_sel_reg;
    logic             irq_pend_reg;

    // Bus decode
    logic [9:0] idx;
    logic       bus_req;
    logic       wr_en;
    logic       irq_pend_next;

    assign idx     = wb_adr[11:2];
    assign bus_req = wb_cyc && wb_stb && !wb_ack;
    assign wr_en   = bus_req && wb_we && wb_sel[0];

    csit_pit_if pit_bus ();

    // Field views
    logic [2:0] cpu_spd;
    logic [1:0] sleep_sel;
    logic       cont_mon;
    logic [1:0] cap_div_code;
    logic [1:0] cap_sel_req;
    logic [1:0] int_div_code;
    logic [1:0] int_sel_req;

    assign cpu_spd      = osc_ctl0_reg[CPU_SPD_LSB +: 3];
    assign sleep_sel    = osc_ctl0_reg[SLEEP_SEL_LSB +: 2];
    assign cont_mon     = osc_ctl0_reg[CONT_MON_BIT];
    assign cap_div_code = tmr_cfg_reg[CAP_DIV_LSB +: 2];
    assign cap_sel_req  = tmr_cfg_reg[CAP_SEL_LSB +: 2];
    assign int_div_code = tmr_cfg_reg[INT_DIV_LSB +: 2];
    assign int_sel_req  = tmr_cfg_reg[INT_SEL_LSB +: 2];

    // Is a capture source code a running clock
    function automatic logic cap_src_runs(input logic [1:0] sel, input logic f,
                                          input logic s);
        unique case (sel)
            SRC_FAST: cap_src_runs = f;
            SRC_SLOW: cap_src_runs = s;
            default:  cap_src_runs = 1'b0;   // Stopped or reserved
        endcase
    endfunction : cap_src_runs

    // Is an interval source code a running clock
    function automatic logic int_src_runs(input logic [1:0] sel, input logic f,
                                          input logic s, input logic c);
        unique case (sel)
            SRC_FAST: int_src_runs = f;
            SRC_SLOW: int_src_runs = s;
            SRC_CAP:  int_src_runs = c;
            default:  int_src_runs = 1'b0;   // Reserved code
        endcase
    endfunction : int_src_runs

    logic cap_runs;
    logic cap_switch_ok;
    logic int_switch_ok;

    assign cap_runs = cap_src_runs(cap_sel_reg, fast_osc_running, slow_osc_running);

    // Stopping the capture clock needs only the old source running;
    // leaving a stopped capture clock never completes
    assign cap_switch_ok = cap_runs
        && ((cap_sel_req == SRC_STOP)
            || cap_src_runs(cap_sel_req, fast_osc_running, slow_osc_running)); // see RULE_11
    assign int_switch_ok =
        int_src_runs(int_sel_reg, fast_osc_running, slow_osc_running, cap_runs)
        && int_src_runs(int_sel_req, fast_osc_running, slow_osc_running, cap_runs); // see RULE_11

    // Register writes; unmapped and read-only indexes ignore writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_ctl0_reg <= OSC_CTL0_RST;                  // see RULE_02
            tmr_cfg_reg  <= TMR_CFG_RST;
            reload_reg   <= RELOAD_RST;
        end else if (wr_en) begin
            unique case (idx)
                OSC_CTL0_IDX:  osc_ctl0_reg <= {2'h0, wb_dat_w[5:0]};
                TMR_CFG_IDX:   tmr_cfg_reg  <= wb_dat_w[7:0];
                // Halves are written separately while the counter runs
                RELOAD_LO_IDX: reload_reg[7:0]  <= wb_dat_w[7:0];   // see RULE_14
                RELOAD_HI_IDX: reload_reg[11:8] <= wb_dat_w[3:0];   // see RULE_14
                default: ;
            endcase
        end
    end

    // Active sources follow the requests only when the switch can complete
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_sel_reg <= TMR_CFG_RST[CAP_SEL_LSB +: 2];
            int_sel_reg <= TMR_CFG_RST[INT_SEL_LSB +: 2];
        end else begin
            if (cap_sel_req != cap_sel_reg && cap_switch_ok) begin
                cap_sel_reg <= cap_sel_req;                 // see RULE_11
            end
            if (int_sel_req != int_sel_reg && int_switch_ok) begin
                int_sel_reg <= int_sel_req;                 // see RULE_11
            end
        end
    end

    // Processor clock enable from the fast oscillator
    csit_div #(.W(DIV_W)) u_cpu_div (
        .clk      (clk),
        .arst_n   (arst_n),
        .tick_in  (fast_osc_tick),
        .divisor  (cpu_divisor(cpu_spd)),                  // see RULE_01
        .tick_out (processor_clock_en)
    );

    // Sleep tick from the slow oscillator: 512, 64, 8 or 1 Hz
    logic [DIV_W-1:0] sleep_div;
    assign sleep_div = DIV_W'(SLEEP_BASE_DIV
        << (SLEEP_STEP_SHIFT * int'(sleep_sel)));          // see RULE_03

    csit_div #(.W(DIV_W)) u_sleep_div (
        .clk      (clk),
        .arst_n   (arst_n),
        .tick_in  (slow_osc_tick),
        .divisor  (sleep_div),
        .tick_out (sleep_tick)
    );

    // Capture clock: source mux then divide by 2, 4, 6, 8
    logic             cap_src_tick;
    logic [DIV_W-1:0] cap_div;

    always_comb begin
        unique case (cap_sel_reg)
            SRC_FAST: cap_src_tick = fast_osc_tick;        // see RULE_08
            SRC_SLOW: cap_src_tick = slow_osc_tick;        // see RULE_08
            default:  cap_src_tick = 1'b0;                 // Stopped
        endcase
    end
    assign cap_div = DIV_W'({cap_div_code, 1'b0}) + DIV_W'(2); // see RULE_07

    csit_div #(.W(DIV_W)) u_cap_div (
        .clk      (clk),
        .arst_n   (arst_n),
        .tick_in  (cap_src_tick),
        .divisor  (cap_div),
        .tick_out (capture_clock_en)
    );

    // Fixed interval: 4096 capture ticks, so it scales with the capture rate
    csit_div #(.W(DIV_W)) u_fixed_div (
        .clk      (clk),
        .arst_n   (arst_n),
        .tick_in  (capture_clock_en),                     // see RULE_16
        .divisor  (FIXED_DIV),
        .tick_out (fixed_interval_tick)
    );

    // Interval clock: source mux then divide by 1 to 4
    logic             int_src_tick;
    logic [DIV_W-1:0] int_div;

    always_comb begin
        unique case (int_sel_reg)
            SRC_FAST: int_src_tick = fast_osc_tick;        // see RULE_10
            SRC_SLOW: int_src_tick = slow_osc_tick;        // see RULE_10
            SRC_CAP:  int_src_tick = capture_clock_en;     // see RULE_10
            default:  int_src_tick = 1'b0;                 // Reserved code
        endcase
    end
    assign int_div = DIV_W'(int_div_code) + DIV_W'(1);    // see RULE_09

    csit_div #(.W(DIV_W)) u_int_div (
        .clk      (clk),
        .arst_n   (arst_n),
        .tick_in  (int_src_tick),
        .divisor  (int_div),
        .tick_out (interval_clock_en)
    );

    // Interval down-counter
    assign pit_bus.reload_value = reload_reg;

    csit_pit u_pit (
        .clk    (clk),
        .arst_n (arst_n),
        .tick   (interval_clock_en),
        .pit    (pit_bus.timer)
    );

    // Interrupt waits for the next processor clock enable so the CPU
    // never misses a reload that falls between its slow clock edges;
    // a reload on the release cycle keeps the request pending
    assign irq_pend_next = pit_bus.reload_pulse
        || (irq_pend_reg && !processor_clock_en);          // see RULE_20

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_pend_reg <= 1'b0;
            interval_irq <= 1'b0;
        end else begin
            irq_pend_reg <= irq_pend_next;
            interval_irq <= irq_pend_reg && processor_clock_en; // see RULE_13
        end
    end

    // Supply monitor: always on when awake; in sleep, continuous or duty cycled.
    // The duty input is not tied to the sleep tick at all.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            supply_monitor_en <= 1'b1;
        end else if (!sleep_active) begin
            supply_monitor_en <= 1'b1;
        end else if (cont_mon) begin
            supply_monitor_en <= 1'b1;                     // see RULE_04
        end else begin
            supply_monitor_en <= sleep_duty_on;            // see RULE_05, see RULE_06
        end
    end

    // Read mux; reserved and unmapped indexes read zero
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            CPU_RSVD_IDX:  rd_byte = 8'h00;
            OSC_CTL0_IDX:  rd_byte = osc_ctl0_reg;
            TMR_CFG_IDX:   rd_byte = tmr_cfg_reg;
            RELOAD_LO_IDX: rd_byte = reload_reg[7:0];              // see RULE_14
            RELOAD_HI_IDX: rd_byte = {4'h0, reload_reg[11:8]};
            COUNT_LO_IDX:  rd_byte = pit_bus.count[7:0];
            COUNT_HI_IDX:  rd_byte = {4'h0, pit_bus.count[11:8]};
            STATUS_IDX:    rd_byte = {2'h0,
                                      cap_sel_req != cap_sel_reg,
                                      int_sel_req != int_sel_reg,
                                      cap_sel_reg, int_sel_reg};
            default:       rd_byte = 8'h00;
        endcase
    end

    // Single-cycle answer; ack drops the cycle after it was given
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack   <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack <= bus_req;
            if (bus_req && !wb_we) begin
                wb_dat_r <= {24'h00_0000, rd_byte};
            end
        end
    end

endmodule : csit_top

`default_nettype wire

//--- verif/csit_props.sv
/*
 * Concurrent checks on the clock select and interval timer top ports.
 * Assumes one clock domain, clk, with arst_n as its asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none

module csit_props (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        wb_cyc,
    input wire logic        wb_stb,
    input wire logic        wb_we,
    input wire logic [31:0] wb_dat_r,
    input wire logic        wb_ack,
    input wire logic        sleep_active,
    input wire logic        processor_clock_en,
    input wire logic        sleep_tick,
    input wire logic        fixed_interval_tick,
    input wire logic        interval_irq,
    input wire logic        supply_monitor_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // A taken request, and the quiet stretch after a fixed interval tick
    sequence bus_req_s;
        wb_cyc && wb_stb && !wb_ack;
    endsequence
    sequence fixed_quiet_s;
        !fixed_interval_tick [*8];
    endsequence

    // Bus answer comes exactly one cycle after a taken request
    ack_timing_a: assert property (bus_req_s |=> wb_ack)
        else $error("ack missing after request");
    ack_pulse_a: assert property (wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
        else $error("ack without request");
    read_width_a: assert property (wb_ack && !wb_we |-> wb_dat_r[31:8] == 24'h0)
        else $error("read data upper bits set");
    // Interrupt rides on the processor enable, one cycle wide
    irq_align_a: assert property (interval_irq |-> $past(processor_clock_en))
        else $error("interrupt not aligned to processor enable");
    irq_single_a: assert property (interval_irq |=> !interval_irq)
        else $error("interrupt longer than one cycle");
    // Fastest processor rate is half the fast oscillator
    cpu_min_div_a: assert property (processor_clock_en |=> !processor_clock_en)
        else $error("processor enable too fast");
    sleep_gap_a: assert property (sleep_tick |=> !sleep_tick [*8])
        else $error("sleep tick too fast");
    fixed_gap_a: assert property (fixed_interval_tick |=> fixed_quiet_s)
        else $error("fixed interval tick too fast");
    // Supply monitor is always on while awake
    monitor_awake_a: assert property (!sleep_active |=> supply_monitor_en)
        else $error("supply monitor off while awake");
endmodule : csit_props

bind csit_top csit_props u_props (
    .clk(clk), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .sleep_active(sleep_active),
    .processor_clock_en(processor_clock_en), .sleep_tick(sleep_tick),
    .fixed_interval_tick(fixed_interval_tick), .interval_irq(interval_irq),
    .supply_monitor_en(supply_monitor_en)
);

`default_nettype wire

//--- verif/tb.sv
/*
 * Self-checking bench for the clock select and interval timer block.
 * Assumes oscillator ticks may be held high for one tick every clk.
 */
`timescale 1ns/100ps
`default_nettype none

module tb
    import csit_pkg::*;
;
    logic        clk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [11:0] wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, q, q1, q2;
    logic        fast_osc_tick, slow_osc_tick, fast_osc_running, slow_osc_running;
    logic        sleep_active, sleep_duty_on, supply_monitor_en;
    logic        processor_clock_en, capture_clock_en, interval_clock_en;
    logic        sleep_tick, fixed_interval_tick, interval_irq;
    logic [5:0]  pulses;
    int          fail_count, check_count, c;
    int          cpu_tab [8] = '{8, 4, 2, 8, 16, 32, 128, 8};

    // Pulse outputs gathered so one task can time any of them
    assign pulses = {interval_irq, fixed_interval_tick, sleep_tick,
                     interval_clock_en, capture_clock_en, processor_clock_en};

    csit_top dut (
        .clk(clk), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .fast_osc_tick(fast_osc_tick), .slow_osc_tick(slow_osc_tick),
        .fast_osc_running(fast_osc_running), .slow_osc_running(slow_osc_running),
        .sleep_active(sleep_active), .sleep_duty_on(sleep_duty_on),
        .processor_clock_en(processor_clock_en), .capture_clock_en(capture_clock_en),
        .interval_clock_en(interval_clock_en), .sleep_tick(sleep_tick),
        .fixed_interval_tick(fixed_interval_tick), .interval_irq(interval_irq),
        .supply_monitor_en(supply_monitor_en)
    );

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Classic single cycle; held until ack is sampled high, then released
    task automatic wb_xfer(input logic we, input logic [9:0] idx, input logic [7:0] d,
                           input logic [3:0] sel, output logic [31:0] r);
        int n = 0;
        @(posedge clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= {idx, 2'h0};
        wb_sel   <= sel;
        wb_dat_w <= {24'h0, d};
        do @(posedge clk); while (wb_ack !== 1'b1 && ++n < 100);
        chk(wb_ack, 1'b1);
        r = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] r;
        wb_xfer(1'b1, idx, d, 4'h1, r);
    endtask : wr

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        wb_xfer(1'b0, idx, 8'h00, 4'hf, r);
        chk(r, exp);
    endtask : rd_chk

    // Skip two pulses so a stale count after reprogramming is not timed
    task automatic period(input int k, input int exp);
        int n;
        for (int i = 0; i < 2; i++) begin
            n = 0;
            do @(posedge clk); while (pulses[k] !== 1'b1 && ++n < 70000);
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pulses[k] !== 1'b1 && n < 70000);
        chk(32'(n), 32'(exp));
    endtask : period

    task automatic count_in(input int k, input int cyc, output int cnt);
        cnt = 0;
        repeat (cyc) begin
            @(posedge clk);
            if (pulses[k] === 1'b1) cnt++;
        end
    endtask : count_in

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report

    // Hang guard, well above the roughly 35k cycles the sequence needs
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        final_report;
    end

    // Main sequence
    // Gain and trim registers live outside this block
    initial begin
        fail_count = 0;
        check_count = 0;
        {arst_n, wb_cyc, wb_stb, wb_we, sleep_active, sleep_duty_on} = 6'h00;
        {wb_adr, wb_sel, wb_dat_w} = '0;
        {fast_osc_tick, slow_osc_tick, fast_osc_running, slow_osc_running} = 4'hf;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd_chk(OSC_CTL0_IDX, 32'h08);
        rd_chk(TMR_CFG_IDX, 32'h8f);
        rd_chk(RELOAD_LO_IDX, 32'h00);
        period(0, 8);
        // Reserved, unmapped and lane-disabled writes leave nothing behind
        wr(CPU_RSVD_IDX, 8'hff);
        rd_chk(CPU_RSVD_IDX, 32'h00);
        wr(10'h100, 8'h5a);
        rd_chk(10'h100, 32'h00);
        wb_xfer(1'b1, TMR_CFG_IDX, 8'h00, 4'h0, q);
        rd_chk(TMR_CFG_IDX, 32'h8f);
        // Every speed code, reserved ones included; top bits read zero
        for (int s = 0; s < 8; s++) begin
            wr(OSC_CTL0_IDX, 8'(8'hc8 | s));
            rd_chk(OSC_CTL0_IDX, 32'(8'h08 | s));
            period(0, cpu_tab[s]);
        end
        for (int s = 0; s < 3; s++) begin
            wr(OSC_CTL0_IDX, 8'((s << 3) | 2));
            period(3, 64 << (3 * s));
        end
        for (int d = 0; d < 4; d++) begin
            wr(TMR_CFG_IDX, 8'(d << 6));
            period(1, 2 * (d + 1));
            wr(TMR_CFG_IDX, 8'(d << 2));
            period(2, d + 1);
        end
        wr(TMR_CFG_IDX, 8'h43);
        period(2, 4);
        wr(TMR_CFG_IDX, 8'h00);
        period(4, FIXED_INTERVAL_US * CAPTURE_NOMINAL_MHZ * 2);
        // Reload of 9 on a /4 interval clock reloads every 40 clk
        wr(TMR_CFG_IDX, 8'h0c);
        wr(RELOAD_LO_IDX, 8'h09);
        wr(RELOAD_HI_IDX, 8'h00);
        rd_chk(RELOAD_LO_IDX, 32'h09);
        repeat (100) @(posedge clk);
        count_in(5, 400, c);
        chk(32'(c), 32'd10);
        c = 0;
        do begin
            wb_xfer(1'b0, COUNT_LO_IDX, 8'h00, 4'hf, q);
            q1 = q;
            wb_xfer(1'b0, COUNT_LO_IDX, 8'h00, 4'hf, q);
            q2 = q;
        end while (q1 != q2 && ++c < 20);
        chk(32'(q2 <= 9), 32'h1);
        wr(RELOAD_HI_IDX, 8'hf3);
        rd_chk(RELOAD_HI_IDX, 32'h03);
        // A switch waits while the new source is stopped
        slow_osc_running <= 1'b0;
        wr(TMR_CFG_IDX, 8'h0e);
        rd_chk(STATUS_IDX, 32'h10);
        slow_osc_running <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(STATUS_IDX, 32'h02);
        // Supply monitor gating in sleep
        sleep_active <= 1'b1;
        wr(OSC_CTL0_IDX, 8'h22);
        repeat (3) @(posedge clk);
        chk(supply_monitor_en, 1'b1);
        wr(OSC_CTL0_IDX, 8'h1a);
        sleep_duty_on <= 1'b1;
        repeat (3) @(posedge clk);
        chk(supply_monitor_en, 1'b1);
        sleep_duty_on <= 1'b0;
        repeat (3) @(posedge clk);
        chk(supply_monitor_en, 1'b0);
        sleep_active <= 1'b0;
        repeat (3) @(posedge clk);
        chk(supply_monitor_en, 1'b1);
        // Stopping capture works; leaving the stopped state never does
        wr(TMR_CFG_IDX, 8'h32);
        repeat (4) @(posedge clk);
        count_in(1, 100, c);
        chk(32'(c), 32'd0);
        wr(TMR_CFG_IDX, 8'h02);
        repeat (4) @(posedge clk);
        rd_chk(STATUS_IDX, 32'h2e);
        final_report;
    end
endmodule : tb

`default_nettype wire
